//--- inc/efl_map.svh
// Register offsets, field positions and reset values of the FIFO layout bank
`ifndef EFL_MAP_SVH
`define EFL_MAP_SVH
// ****************************************************************
// Register byte offsets
// ****************************************************************
`define EFL_OFS_TX_SIZE 4'h0
`define EFL_OFS_RX_SIZE 4'h4
`define EFL_OFS_TX_LOC 4'h8
`define EFL_OFS_W 4
// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define EFL_DBL_BIT 4
`define EFL_CODE_HI 3
`define EFL_LOC_HI 12
`define EFL_SIZE_MASK 8'h1f
`define EFL_LOC_MASK 16'h1fff
`define EFL_SIZE_RST 8'h00
`define EFL_LOC_RST 16'h0000
`define EFL_SINGLE_ADD 5'h03
`define EFL_DOUBLE_ADD 5'h04
`define EFL_LOC_SHIFT 3
`define EFL_RESP_OKAY 2'h0
`define EFL_RESP_SLVERR 2'h2
`endif

//--- inc/efl_pkg.sv
// Types shared by the FIFO layout bank
package efl_pkg;
  typedef enum logic [2:0] {
    EFL_IDLE = 3'b001,
    EFL_WRSP = 3'b010,
    EFL_RRSP = 3'b100
  } efl_state_t;
endpackage

//--- rtl/efl_size_dec.sv
// Decoder from one size register to FIFO size and packet limit
`timescale 1ns/1ps
`include "efl_map.svh"
module efl_size_dec (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic en_in,
  // Size register
  input wire logic [7:0] cfg_in,
  // Decoded outputs
  output logic [19:0] fifo_bytes_out,
  output logic [18:0] max_pkt_out,
  output logic dbl_out
);
  typedef struct packed {
    logic [19:0] bytes;
    logic [18:0] pkt;
    logic dbl;
  } efl_dec_t;
  efl_dec_t st_reg, st_next;

  // Power of two of a 5-bit exponent; code 15 doubled needs bit 19
  function automatic logic [19:0] efl_pow2(input logic [4:0] e);
    efl_pow2 = 20'h00001 << e;
  endfunction

  // Size from code and buffering mode
  always_comb begin
    logic [4:0] code;
    code = {1'b0, cfg_in[`EFL_CODE_HI:0]};
    st_next = st_reg;
    st_next.dbl = cfg_in[`EFL_DBL_BIT];
    if (cfg_in[`EFL_DBL_BIT]) begin
      st_next.bytes = efl_pow2(code + `EFL_DOUBLE_ADD);
    end else begin
      st_next.bytes = efl_pow2(code + `EFL_SINGLE_ADD);
    end
    st_next.pkt = 19'(efl_pow2(code + `EFL_SINGLE_ADD));
  end

  // State register
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_reg <= '0;
    end else if (en_in) begin
      st_reg <= st_next;
    end
  end

  assign fifo_bytes_out = st_reg.bytes;
  assign max_pkt_out = st_reg.pkt;
  assign dbl_out = st_reg.dbl;
endmodule

//--- rtl/efl_loc_dec.sv
// Decoder from start location register to FIFO byte address
`timescale 1ns/1ps
`include "efl_map.svh"
module efl_loc_dec (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic en_in,
  // Location register
  input wire logic [15:0] loc_in,
  // Byte address
  output logic [15:0] byte_addr_out
);
  typedef struct packed {
    logic [15:0] addr;
  } efl_loc_t;
  efl_loc_t st_reg, st_next;

  // Eight-byte units to bytes
  always_comb begin
    st_next = st_reg;
    st_next.addr = {loc_in[`EFL_LOC_HI:0], 3'h0};
  end

  // State register
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_reg <= '0;
    end else if (en_in) begin
      st_reg <= st_next;
    end
  end

  assign byte_addr_out = st_reg.addr;
endmodule

//--- rtl/efl_regs.sv
// AXI4-Lite register bank for endpoint FIFO size and start location
`timescale 1ns/1ps
`include "efl_map.svh"
module efl_regs (
  // Clock, reset, enable
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  // AXI4-Lite write address
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_awaddr_in,
  // AXI4-Lite write data
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  // AXI4-Lite write response
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  output logic [1:0] s_axi_bresp_out,
  // AXI4-Lite read address
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  input wire logic [31:0] s_axi_araddr_in,
  // AXI4-Lite read data
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  // Decoded FIFO layout
  output logic [19:0] tx_fifo_bytes_out,
  output logic [18:0] tx_max_pkt_out,
  output logic tx_double_buffer_en_out,
  output logic [19:0] rx_fifo_bytes_out,
  output logic [18:0] rx_max_pkt_out,
  output logic rx_double_buffer_en_out,
  output logic [15:0] tx_fifo_byte_addr_out
);
  typedef struct packed {
    efl_pkg::efl_state_t wst;
    efl_pkg::efl_state_t rst;
    logic aw_got;
    logic w_got;
    logic [`EFL_OFS_W-1:0] awaddr;
    logic aw_ok;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [1:0] bresp;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] tx_size;
    logic [7:0] rx_size;
    logic [15:0] tx_loc;
  } efl_st_t;
  efl_st_t st_reg, st_next;

  // Word decode: aligned, upper bits zero, known offset
  function automatic logic efl_hit(input logic [31:0] a);
    logic [`EFL_OFS_W-1:0] o;
    o = a[`EFL_OFS_W-1:0];
    efl_hit = (a[31:`EFL_OFS_W] == 28'h0000000) &&
      (o == `EFL_OFS_TX_SIZE || o == `EFL_OFS_RX_SIZE ||
       o == `EFL_OFS_TX_LOC);
  endfunction

  // Byte-lane merge of a write into a 16-bit register
  function automatic logic [15:0] efl_merge(input logic [15:0] old,
      input logic [31:0] d, input logic [3:0] s);
    efl_merge = old;
    if (s[0]) begin
      efl_merge[7:0] = d[7:0];
    end
    if (s[1]) begin
      efl_merge[15:8] = d[15:8];
    end
  endfunction

  // Bus handshakes and register updates
  always_comb begin
    logic [15:0] m;
    logic [`EFL_OFS_W-1:0] ro;
    m = 16'h0000;
    ro = s_axi_araddr_in[`EFL_OFS_W-1:0];
    st_next = st_reg;
    unique case (st_reg.wst)
      efl_pkg::EFL_IDLE: begin
        if (s_axi_awvalid_in && !st_reg.aw_got) begin
          st_next.aw_got = 1'b1;
          st_next.awaddr = s_axi_awaddr_in[`EFL_OFS_W-1:0];
          st_next.aw_ok = efl_hit(s_axi_awaddr_in);
        end
        if (s_axi_wvalid_in && !st_reg.w_got) begin
          st_next.w_got = 1'b1;
          st_next.wdata = s_axi_wdata_in;
          st_next.wstrb = s_axi_wstrb_in;
        end
        if (st_reg.aw_got && st_reg.w_got) begin
          st_next.aw_got = 1'b0;
          st_next.w_got = 1'b0;
          st_next.wst = efl_pkg::EFL_WRSP;
          st_next.bresp = st_reg.aw_ok ? `EFL_RESP_OKAY : `EFL_RESP_SLVERR;
          if (st_reg.aw_ok) begin
            unique case (st_reg.awaddr)
              `EFL_OFS_TX_SIZE: begin
                m = efl_merge({8'h00, st_reg.tx_size}, st_reg.wdata,
                  st_reg.wstrb);
                st_next.tx_size = m[7:0] & `EFL_SIZE_MASK;
              end
              `EFL_OFS_RX_SIZE: begin
                m = efl_merge({8'h00, st_reg.rx_size}, st_reg.wdata,
                  st_reg.wstrb);
                st_next.rx_size = m[7:0] & `EFL_SIZE_MASK;
              end
              default: begin
                m = efl_merge(st_reg.tx_loc, st_reg.wdata, st_reg.wstrb);
                st_next.tx_loc = m & `EFL_LOC_MASK;
              end
            endcase
          end
        end
      end
      efl_pkg::EFL_WRSP: begin
        if (s_axi_bready_in) begin
          st_next.wst = efl_pkg::EFL_IDLE;
        end
      end
      default: begin
        st_next.wst = efl_pkg::EFL_IDLE;
      end
    endcase
    unique case (st_reg.rst)
      efl_pkg::EFL_IDLE: begin
        if (s_axi_arvalid_in) begin
          st_next.rst = efl_pkg::EFL_RRSP;
          st_next.rdata = 32'h00000000;
          st_next.rresp = `EFL_RESP_SLVERR;
          if (efl_hit(s_axi_araddr_in)) begin
            st_next.rresp = `EFL_RESP_OKAY;
            unique case (ro)
              `EFL_OFS_TX_SIZE: begin
                st_next.rdata = {24'h000000,
                  st_reg.tx_size & `EFL_SIZE_MASK};
              end
              `EFL_OFS_RX_SIZE: begin
                st_next.rdata = {24'h000000,
                  st_reg.rx_size & `EFL_SIZE_MASK};
              end
              default: begin
                st_next.rdata = {16'h0000,
                  st_reg.tx_loc & `EFL_LOC_MASK};
              end
            endcase
          end
        end
      end
      efl_pkg::EFL_RRSP: begin
        if (s_axi_rready_in) begin
          st_next.rst = efl_pkg::EFL_IDLE;
        end
      end
      default: begin
        st_next.rst = efl_pkg::EFL_IDLE;
      end
    endcase
  end

  // State register, reset to zero with both state machines in idle
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_reg <= '0;
      st_reg.wst <= efl_pkg::EFL_IDLE;
      st_reg.rst <= efl_pkg::EFL_IDLE;
      st_reg.tx_size <= `EFL_SIZE_RST;
      st_reg.rx_size <= `EFL_SIZE_RST;
      st_reg.tx_loc <= `EFL_LOC_RST;
    end else if (ce_in) begin
      st_reg <= st_next;
    end
  end

  // Bus outputs straight from state
  assign s_axi_awready_out = (st_reg.wst == efl_pkg::EFL_IDLE) &&
    !st_reg.aw_got;
  assign s_axi_wready_out = (st_reg.wst == efl_pkg::EFL_IDLE) &&
    !st_reg.w_got;
  assign s_axi_bvalid_out = (st_reg.wst == efl_pkg::EFL_WRSP);
  assign s_axi_bresp_out = st_reg.bresp;
  assign s_axi_arready_out = (st_reg.rst == efl_pkg::EFL_IDLE);
  assign s_axi_rvalid_out = (st_reg.rst == efl_pkg::EFL_RRSP);
  assign s_axi_rdata_out = st_reg.rdata;
  assign s_axi_rresp_out = st_reg.rresp;

  // Transmit size decode
  efl_size_dec u_tx_dec (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .en_in(ce_in),
    .cfg_in(st_reg.tx_size),
    .fifo_bytes_out(tx_fifo_bytes_out),
    .max_pkt_out(tx_max_pkt_out),
    .dbl_out(tx_double_buffer_en_out)
  );

  // Receive size decode
  efl_size_dec u_rx_dec (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .en_in(ce_in),
    .cfg_in(st_reg.rx_size),
    .fifo_bytes_out(rx_fifo_bytes_out),
    .max_pkt_out(rx_max_pkt_out),
    .dbl_out(rx_double_buffer_en_out)
  );

  // Transmit start location decode
  efl_loc_dec u_loc_dec (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .en_in(ce_in),
    .loc_in(st_reg.tx_loc),
    .byte_addr_out(tx_fifo_byte_addr_out)
  );
endmodule

//--- bench/efl_regs_chk.sv
// Checker of write latency and decoded FIFO layout of the register bank
`timescale 1ns/1ps
`include "efl_map.svh"
module efl_regs_chk (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Register bus
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic [31:0] s_axi_awaddr_in,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_rvalid_out,
  input wire logic [31:0] s_axi_rdata_out,
  // Decoded layout
  input wire logic [19:0] tx_fifo_bytes_out,
  input wire logic [18:0] tx_max_pkt_out,
  input wire logic tx_double_buffer_en_out,
  input wire logic [19:0] rx_fifo_bytes_out,
  input wire logic [18:0] rx_max_pkt_out,
  input wire logic rx_double_buffer_en_out,
  input wire logic [15:0] tx_fifo_byte_addr_out
);
  logic [3:0] a_q;
  logic [15:0] d_q;
  logic [1:0] s_q;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  // Capture of the last accepted write
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      a_q <= 4'hf;
      d_q <= 16'h0;
      s_q <= 2'h0;
    end else if (s_axi_awvalid_in && s_axi_awready_out) begin
      a_q <= s_axi_awaddr_in[3:0];
      d_q <= s_axi_wdata_in[15:0];
      s_q <= s_axi_wstrb_in[1:0];
    end
  end
  AST_TX_RATIO: assert property (tx_fifo_bytes_out ==
    (tx_double_buffer_en_out ? {tx_max_pkt_out, 1'h0} : {1'h0, tx_max_pkt_out}))
    else $error("tx fifo size not tied to packet size");
  AST_RX_RATIO: assert property (rx_fifo_bytes_out ==
    (rx_double_buffer_en_out ? {rx_max_pkt_out, 1'h0} : {1'h0, rx_max_pkt_out}))
    else $error("rx fifo size not tied to packet size");
  AST_PKT_POW2: assert property ($past(rstn_in) |->
    $onehot(tx_max_pkt_out) && $onehot(rx_max_pkt_out))
    else $error("packet limit not a power of two");
  AST_ADDR_ALIGN: assert property (tx_fifo_byte_addr_out[2:0] == 3'h0)
    else $error("start address not on 8 bytes");
  AST_B_LAT: assert property (s_axi_awvalid_in && s_axi_awready_out &&
    s_axi_wvalid_in && s_axi_wready_out |-> ##2 s_axi_bvalid_out)
    else $error("write response late");
  AST_TX_WR: assert property ($rose(s_axi_bvalid_out) && s_q[0] &&
    a_q == `EFL_OFS_TX_SIZE |=> tx_double_buffer_en_out == d_q[4] &&
    tx_max_pkt_out == 19'h8 << d_q[3:0])
    else $error("tx size write not decoded");
  AST_RX_WR: assert property ($rose(s_axi_bvalid_out) && s_q[0] &&
    a_q == `EFL_OFS_RX_SIZE |=>
    rx_fifo_bytes_out == 20'h8 << ({1'h0, d_q[3:0]} + 5'(d_q[4])))
    else $error("rx size write not decoded");
  AST_LOC_WR: assert property ($rose(s_axi_bvalid_out) &&
    s_q == 2'h3 && a_q == `EFL_OFS_TX_LOC |=>
    tx_fifo_byte_addr_out == {d_q[12:0], 3'h0})
    else $error("start location write not decoded");
  AST_RD_RSV: assert property (s_axi_rvalid_out |->
    s_axi_rdata_out[31:16] == 16'h0)
    else $error("read data above 16 bits not zero");
endmodule
bind efl_regs efl_regs_chk efl_regs_chk_i (.clk_in, .rstn_in,
  .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_awaddr_in, .s_axi_wvalid_in,
  .s_axi_wready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_bvalid_out,
  .s_axi_rvalid_out, .s_axi_rdata_out, .tx_fifo_bytes_out, .tx_max_pkt_out,
  .tx_double_buffer_en_out, .rx_fifo_bytes_out, .rx_max_pkt_out,
  .rx_double_buffer_en_out, .tx_fifo_byte_addr_out);

//--- bench/efl_regs_tb.sv
// Self-checking testbench of the endpoint FIFO layout register bank
`timescale 1ns/1ps
`include "efl_map.svh"
module efl_regs_tb;
  logic clk_in, rstn_in, awv, awr, wv, wr_rdy, bv, br, arv, arr, rv, rr;
  logic [31:0] awa, wd, ara, rd_d;
  logic [3:0] ws;
  logic [1:0] bresp, rresp, r;
  logic [19:0] txb, rxb;
  logic [18:0] txp, rxp;
  logic txd, rxd;
  logic [15:0] txa;
  logic [31:0] d;
  int mismatches, total_checks, cycles;
  efl_regs efl_regs_i (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(1'h1),
    .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_awaddr_in(awa),
    .s_axi_wvalid_in(wv), .s_axi_wready_out(wr_rdy), .s_axi_wdata_in(wd),
    .s_axi_wstrb_in(ws), .s_axi_bvalid_out(bv), .s_axi_bready_in(br),
    .s_axi_bresp_out(bresp), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
    .s_axi_araddr_in(ara), .s_axi_rvalid_out(rv), .s_axi_rready_in(rr),
    .s_axi_rdata_out(rd_d), .s_axi_rresp_out(rresp), .tx_fifo_bytes_out(txb),
    .tx_max_pkt_out(txp), .tx_double_buffer_en_out(txd),
    .rx_fifo_bytes_out(rxb), .rx_max_pkt_out(rxp),
    .rx_double_buffer_en_out(rxd), .tx_fifo_byte_addr_out(txa));
  // ***********
  // Report, check and bus tasks
  // ***********
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] v,
                    input logic [3:0] s);
    @(posedge clk_in);
    awa <= a; wd <= v; ws <= s; awv <= 1'h1; wv <= 1'h1; br <= 1'h1;
    do begin
      @(posedge clk_in);
      if (awr) awv <= 1'h0;
      if (wr_rdy) wv <= 1'h0;
    end while (!bv);
    r = bresp;
    br <= 1'h0;
  endtask
  task automatic rd(input logic [31:0] a);
    @(posedge clk_in);
    ara <= a; arv <= 1'h1; rr <= 1'h1;
    do begin
      @(posedge clk_in);
      if (arr) arv <= 1'h0;
    end while (!rv);
    d = rd_d;
    r = rresp;
    rr <= 1'h0;
  endtask
  // ***********
  // Scenarios
  // ***********
  task automatic t_reset();
    rstn_in <= 1'h0;
    repeat (4) @(posedge clk_in);
    rstn_in <= 1'h1;
    for (int i = 0; i < 12; i += 4) begin
      rd(32'(i));
      chk(d, 32'h0);
    end
    chk(32'(txb), 32'h8);
    chk(32'(rxp), 32'h8);
    chk({txd, rxd, txa}, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_size();
    int c, b;
    for (int i = 0; i < 32; i++) begin
      c = i % 16;
      b = i / 16;
      wr(`EFL_OFS_TX_SIZE, {24'h0, 3'h7, b[0], c[3:0]}, 4'h1);
      wr(`EFL_OFS_RX_SIZE, {27'h0, !b[0], ~c[3:0]}, 4'h1);
      rd(`EFL_OFS_TX_SIZE);
      chk(d, {27'h0, b[0], c[3:0]});
      chk(32'(txd), 32'(b));
      chk(32'(txb), 32'h8 << (c + b));
      chk(32'(txp), 32'h8 << c);
      chk(32'(rxd), 32'(1 - b));
      chk(32'(rxb), 32'h8 << (16 - c - b));
    end
    $display("size test done");
  endtask
  task automatic t_loc();
    logic [15:0] v[3] = '{16'hffff, 16'h0001, 16'ha5a5};
    for (int i = 0; i < 3; i++) begin
      wr(`EFL_OFS_TX_LOC, {16'h0, v[i]}, 4'h3);
      rd(`EFL_OFS_TX_LOC);
      chk(d, {19'h0, v[i][12:0]});
      chk(32'(txa), {16'h0, v[i][12:0], 3'h0});
    end
    $display("location test done");
  endtask
  task automatic t_err();
    wr(32'hc, 32'h1f, 4'hf);
    chk(32'(r), 32'(`EFL_RESP_SLVERR));
    rd(32'hc);
    chk({d[29:0], r}, 32'(`EFL_RESP_SLVERR));
    $display("unmapped test done");
  endtask
  // Clock
  initial begin
    clk_in = 1'h0;
    forever #5 clk_in = ~clk_in;
  end
  // Hang guard
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      conclude();
    end
  end
  // Main sequence
  initial begin
    {rstn_in, awv, wv, br, arv, rr, awa, wd, ws, ara} = '0;
    {mismatches, total_checks, cycles} = '0;
    t_reset();
    t_size();
    t_loc();
    t_err();
    t_reset();
    conclude();
  end
endmodule
